// >>> timer_io_control_ch1_ch2.sv
// i/o function control for timer channels 1 and 2 with their general registers
//
// Contract
// - control register: upper nibble sets register B, lower nibble register A
// - field zero: compare register, output disabled, level 0; reset value
// - top bit 0: output compare; bit 2 initial level; low 00 disables output
// - compare with low bits 01 drives pin low on counter match
// - compare with low bits 10 drives pin high on counter match
// - compare with low bits 11 toggles pin on each counter match
// - field 1000 captures counter on rising edge of own pin
// - field 1001 captures counter on falling edge of own pin
// - fields 1010 and 1011 capture counter on both pin edges
// - channel 1 fields 11xx capture on channel 0 register A or C event
// - channel 2 fields 1100, 1101, 111x capture on rising, falling, both edges
`timescale 1ns/1ps
`include "tio_params.svh"
module timer_io_control_ch1_ch2
    import tio_pkg::*;
(
    input  wire logic                       clock,        // 200 MHz timer clock
    input  wire logic                       reset_n,      // async reset, active low
    input  wire reg_req_s                   regReq,       // register port request
    output      logic [`TIO_DATA_WIDTH-1:0] regRdData,    // read data, cycle after read strobe
    input  wire logic [`TIO_DATA_WIDTH-1:0] counterValue, // running timer counter
    input  wire logic                       chan0EventA,  // chan0_general_reg_a match or capture pulse
    input  wire logic                       chan0EventC,  // chan0_general_reg_c match or capture pulse
    input  wire logic [3:0]                 pinIn,        // pin levels, index by pin constants
    output      pin_drive_s [3:0]           pinDrive      // pin level and active-low enable
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]                 chan1IoFunctionCtrl;
        logic [7:0]                 chan2IoFunctionCtrl;
        logic [3:0]                 cfgWritten;
        logic [3:0]                 capFlag;
        logic [3:0]                 matchFlag;
        logic [`TIO_DATA_WIDTH-1:0] rdData;
    } top_state_s;

    top_state_s                 s;
    top_state_s                 next_s;
    func_s                      func       [4];
    logic [3:0]                 grWrite;
    logic [3:0]                 pinRise;
    logic [3:0]                 pinFall;
    logic [3:0]                 crossEvent;
    logic [3:0]                 capPulse;
    logic [3:0]                 matchPulse;
    logic [3:0]                 pinLevel;
    logic [`TIO_DATA_WIDTH-1:0] grValue    [4];

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // picks the nibble of register a or b of a given unit index
    function automatic logic [3:0] field_of(
        input logic [7:0] ctrl1,
        input logic [7:0] ctrl2,
        input int         idx
    );
        logic [7:0] ctrl;
        ctrl = (idx < 2) ? ctrl1 : ctrl2;
        if (idx % 2 == 0) begin
            field_of = ctrl[`TIO_FIELD_A_LSB +: 4];
        end else begin
            field_of = ctrl[`TIO_FIELD_B_LSB +: 4];
        end
    endfunction : field_of

    // turns a four-bit field into the unit's function
    function automatic func_s decode_field(
        input logic [3:0] field,
        input logic       hasCross
    );
        func_s f;
        f           = '0;
        f.mode      = FN_OUT_OFF;
        f.action    = field[1:0];
        f.initLevel = 1'b0;
        f.capRise   = 1'b0;
        f.capFall   = 1'b0;
        if (!field[3]) begin
            f.initLevel = field[2];
            if (field[1:0] == `TIO_ACT_NONE) begin
                f.mode = FN_OUT_OFF;
            end else begin
                f.mode = FN_OUT_CMP;
            end
        end else if (field[2] && hasCross) begin
            f.mode = FN_CAP_CROSS;
        end else begin
            f.mode    = FN_CAP_PIN;
            f.capRise = field[1] | ~field[0];
            f.capFall = field[1] | field[0];
        end
        decode_field = f;
    endfunction : decode_field

    // byte address of a unit's general register
    function automatic logic [7:0] gr_offset(input int idx);
        case (idx)
            `TIO_CHAN1_PIN_A: gr_offset = `TIO_OFS_CHAN1_GR_A;
            `TIO_CHAN1_PIN_B: gr_offset = `TIO_OFS_CHAN1_GR_B;
            `TIO_CHAN2_PIN_A: gr_offset = `TIO_OFS_CHAN2_GR_A;
            default:          gr_offset = `TIO_OFS_CHAN2_GR_B;
        endcase
    endfunction : gr_offset

    // ------------------------------------------------------------
    // per-register units
    // ------------------------------------------------------------
    for (genvar i = 0; i < 4; i++) begin : g_unit
        assign func[i]       = decode_field(field_of(s.chan1IoFunctionCtrl, s.chan2IoFunctionCtrl, i), i < 2);
        assign grWrite[i]    = regReq.wr && (regReq.addr == gr_offset(i));
        assign pinLevel[i]   = pinDrive[i].level;

        pin_edge_sync u_sync (
            .clock   (clock),
            .reset_n (reset_n),
            .pinIn   (pinIn[i]),
            .rise    (pinRise[i]),
            .fall    (pinFall[i])
        );

        gen_reg_unit #(
            .Width (`TIO_DATA_WIDTH)
        ) u_unit (
            .clock        (clock),
            .reset_n      (reset_n),
            .func         (func[i]),
            .cfgWrite     (s.cfgWritten[i]),
            .counterValue (counterValue),
            .pinRise      (pinRise[i]),
            .pinFall      (pinFall[i]),
            .crossEvent   (crossEvent[i]),
            .swWrite      (grWrite[i]),
            .swData       (regReq.wrData),
            .generalReg   (grValue[i]),
            .drive        (pinDrive[i]),
            .capturePulse (capPulse[i]),
            .matchPulse   (matchPulse[i])
        );
    end

    // channel 0 events feed channel 1 only
    assign crossEvent[`TIO_CHAN1_PIN_A] = chan0EventA;
    assign crossEvent[`TIO_CHAN1_PIN_B] = chan0EventC;
    assign crossEvent[`TIO_CHAN2_PIN_A] = 1'b0;
    assign crossEvent[`TIO_CHAN2_PIN_B] = 1'b0;

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    always_comb begin
        next_s            = s;
        next_s.cfgWritten = 4'h0;
        next_s.rdData     = '0;

        // writes
        if (regReq.wr) begin
            case (regReq.addr)
                `TIO_OFS_CHAN1_CTRL: begin
                    next_s.chan1IoFunctionCtrl = regReq.wrData[7:0];
                    next_s.cfgWritten[1:0]     = 2'h3;
                end
                `TIO_OFS_CHAN2_CTRL: begin
                    next_s.chan2IoFunctionCtrl = regReq.wrData[7:0];
                    next_s.cfgWritten[3:2]     = 2'h3;
                end
                default: begin
                    next_s.cfgWritten = 4'h0;
                end
            endcase
        end

        // sticky flags, write one to clear, a new event wins
        next_s.capFlag   = s.capFlag;
        next_s.matchFlag = s.matchFlag;
        if (regReq.wr && regReq.addr == `TIO_OFS_STATUS) begin
            next_s.capFlag   = s.capFlag & ~regReq.wrData[`TIO_STAT_CAP_LSB +: 4];
            next_s.matchFlag = s.matchFlag & ~regReq.wrData[`TIO_STAT_MATCH_LSB +: 4];
        end
        next_s.capFlag   = next_s.capFlag | capPulse;
        next_s.matchFlag = next_s.matchFlag | matchPulse;

        // reads, data stand one cycle only
        if (regReq.rd) begin
            case (regReq.addr)
                `TIO_OFS_CHAN1_CTRL: next_s.rdData = {8'h00, s.chan1IoFunctionCtrl};
                `TIO_OFS_CHAN2_CTRL: next_s.rdData = {8'h00, s.chan2IoFunctionCtrl};
                `TIO_OFS_CHAN1_GR_A: next_s.rdData = grValue[`TIO_CHAN1_PIN_A];
                `TIO_OFS_CHAN1_GR_B: next_s.rdData = grValue[`TIO_CHAN1_PIN_B];
                `TIO_OFS_CHAN2_GR_A: next_s.rdData = grValue[`TIO_CHAN2_PIN_A];
                `TIO_OFS_CHAN2_GR_B: next_s.rdData = grValue[`TIO_CHAN2_PIN_B];
                `TIO_OFS_STATUS:     next_s.rdData = {4'h0, pinLevel, s.matchFlag, s.capFlag};
                default:             next_s.rdData = '0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s                     <= '0;
            s.chan1IoFunctionCtrl <= `TIO_CTRL_RESET;
            s.chan2IoFunctionCtrl <= `TIO_CTRL_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign regRdData = s.rdData;
endmodule : timer_io_control_ch1_ch2

// >>> tio_params.svh
// offsets, field positions, reset values and codes for the timer i/o control block
`ifndef TIO_PARAMS_SVH
`define TIO_PARAMS_SVH

`define TIO_DATA_WIDTH       16
`define TIO_ADDR_WIDTH       8

`define TIO_OFS_CHAN1_CTRL   8'h00
`define TIO_OFS_CHAN2_CTRL   8'h04
`define TIO_OFS_CHAN1_GR_A   8'h08
`define TIO_OFS_CHAN1_GR_B   8'h0C
`define TIO_OFS_CHAN2_GR_A   8'h10
`define TIO_OFS_CHAN2_GR_B   8'h14
`define TIO_OFS_STATUS       8'h18

`define TIO_FIELD_A_LSB      0
`define TIO_FIELD_B_LSB      4
`define TIO_STAT_CAP_LSB     0
`define TIO_STAT_MATCH_LSB   4
`define TIO_STAT_LEVEL_LSB   8

`define TIO_CTRL_RESET       8'h00
`define TIO_GR_RESET         16'hFFFF

`define TIO_ACT_NONE         2'b00
`define TIO_ACT_DRIVE0       2'b01
`define TIO_ACT_DRIVE1       2'b10
`define TIO_ACT_TOGGLE       2'b11

`define TIO_CHAN1_PIN_A      0
`define TIO_CHAN1_PIN_B      1
`define TIO_CHAN2_PIN_A      2
`define TIO_CHAN2_PIN_B      3

`endif

// >>> tio_pkg.sv
// types shared by the timer i/o control block
package tio_pkg;
    typedef enum logic [1:0] {
        FN_OUT_OFF,
        FN_OUT_CMP,
        FN_CAP_PIN,
        FN_CAP_CROSS
    } func_mode_e;

    typedef struct packed {
        func_mode_e mode;
        logic       initLevel;
        logic [1:0] action;
        logic       capRise;
        logic       capFall;
    } func_s;

    typedef struct packed {
        logic level;
        logic enable_n;
    } pin_drive_s;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wrData;
        logic        wr;
        logic        rd;
    } reg_req_s;
endpackage : tio_pkg

// >>> pin_edge_sync.sv
// two-flop pin synchroniser with registered edge pulses
`timescale 1ns/1ps
module pin_edge_sync (
    input  wire logic clock,   // timer clock
    input  wire logic reset_n, // async reset, active low
    input  wire logic pinIn,   // raw pin level
    output      logic rise,    // one-cycle rising edge pulse
    output      logic fall     // one-cycle falling edge pulse
);
    typedef struct packed {
        logic meta;
        logic stable;
        logic prev;
        logic rise;
        logic fall;
    } sync_state_s;

    sync_state_s s;
    sync_state_s next_s;

    always_comb begin
        next_s        = s;
        next_s.meta   = pinIn;
        next_s.stable = s.meta;
        next_s.prev   = s.stable;
        next_s.rise   = s.stable & ~s.prev;
        next_s.fall   = ~s.stable & s.prev;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rise = s.rise;
    assign fall = s.fall;
endmodule : pin_edge_sync

// >>> gen_reg_unit.sv
// one general register with its compare output and capture logic
`timescale 1ns/1ps
`include "tio_params.svh"
module gen_reg_unit
    import tio_pkg::*;
#(
    parameter int Width = `TIO_DATA_WIDTH
) (
    input  wire logic             clock,        // timer clock
    input  wire logic             reset_n,      // async reset, active low
    input  wire func_s            func,         // decoded function field
    input  wire logic             cfgWrite,     // field was just written
    input  wire logic [Width-1:0] counterValue, // timer counter
    input  wire logic             pinRise,      // synchronised pin rising edge
    input  wire logic             pinFall,      // synchronised pin falling edge
    input  wire logic             crossEvent,   // channel 0 event pulse
    input  wire logic             swWrite,      // software write of the register
    input  wire logic [Width-1:0] swData,       // software write data
    output      logic [Width-1:0] generalReg,   // general register value
    output      pin_drive_s       drive,        // pin level and enable
    output      logic             capturePulse, // capture happened
    output      logic             matchPulse    // compare match happened
);
    typedef struct packed {
        logic [Width-1:0] value;
        pin_drive_s       drive;
        logic             wasEqual;
        logic             capture;
        logic             match;
    } unit_state_s;

    unit_state_s s;
    unit_state_s next_s;
    logic        equal;

    always_comb begin
        next_s          = s;
        next_s.capture  = 1'b0;
        next_s.match    = 1'b0;
        equal           = (counterValue == s.value);
        next_s.wasEqual = equal;
        if (swWrite) begin
            next_s.value = swData;
        end
        case (func.mode)
            FN_OUT_OFF: begin
                next_s.drive.enable_n = 1'b1;
                if (cfgWrite) begin
                    next_s.drive.level = func.initLevel;
                end
            end
            FN_OUT_CMP: begin
                next_s.drive.enable_n = 1'b0;
                if (cfgWrite) begin
                    next_s.drive.level = func.initLevel;
                end else if (equal && !s.wasEqual) begin
                    next_s.match = 1'b1;
                    case (func.action)
                        `TIO_ACT_DRIVE0: next_s.drive.level = 1'b0;
                        `TIO_ACT_DRIVE1: next_s.drive.level = 1'b1;
                        `TIO_ACT_TOGGLE: next_s.drive.level = ~s.drive.level;
                        default:         next_s.drive.level = s.drive.level;
                    endcase
                end
            end
            FN_CAP_PIN: begin
                next_s.drive.enable_n = 1'b1;
                if ((pinRise && func.capRise) || (pinFall && func.capFall)) begin
                    next_s.value   = counterValue;
                    next_s.capture = 1'b1;
                end
            end
            FN_CAP_CROSS: begin
                next_s.drive.enable_n = 1'b1;
                if (crossEvent) begin
                    next_s.value   = counterValue;
                    next_s.capture = 1'b1;
                end
            end
            default: begin
                next_s.drive.enable_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s                <= '0;
            s.value          <= `TIO_GR_RESET;
            s.drive.enable_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign generalReg   = s.value;
    assign drive        = s.drive;
    assign capturePulse = s.capture;
    assign matchPulse   = s.match;
endmodule : gen_reg_unit

// >>> timer_io_control_ch1_ch2_props.sv
// port checks for the timer i/o control block
`timescale 1ns/1ps
`include "tio_params.svh"
module timer_io_control_ch1_ch2_props
    import tio_pkg::*;
(
    input wire logic             clock,        // timer clock
    input wire logic             reset_n,      // async reset
    input wire reg_req_s         regReq,       // register request
    input wire logic [15:0]      regRdData,    // read data
    input wire logic [15:0]      counterValue, // timer counter
    input wire logic             chan0EventA,  // chan0 event a
    input wire logic             chan0EventC,  // chan0 event c
    input wire logic [3:0]       pinIn,        // pin levels
    input wire pin_drive_s [3:0] pinDrive      // pin drive
);
    // ----------------------------------------
    // shadow of the control registers
    // ----------------------------------------
    logic [7:0]  ctrl1;
    logic [7:0]  ctrl2;
    logic [15:0] fields;
    logic [3:0]  wrote;
    logic [3:0]  offMode;
    logic [3:0]  initLvl;
    logic [3:0]  canRise;
    logic [3:0]  canFall;
    logic        wr1;
    logic        wr2;
    assign wr1 = regReq.wr && regReq.addr == `TIO_OFS_CHAN1_CTRL;
    assign wr2 = regReq.wr && regReq.addr == `TIO_OFS_CHAN2_CTRL;
    assign fields = {ctrl2, ctrl1};
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl1 <= 8'h00;
            ctrl2 <= 8'h00;
            wrote <= 4'h0;
        end else begin
            ctrl1 <= wr1 ? regReq.wrData[7:0] : ctrl1;
            ctrl2 <= wr2 ? regReq.wrData[7:0] : ctrl2;
            wrote <= {wr2, wr2, wr1, wr1};
        end
    end
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            offMode[i] = fields[4*i+3] || fields[4*i+:2] == 2'b00;
            initLvl[i] = fields[4*i+2];
            canRise[i] = !fields[4*i+3] && fields[4*i+1];
            canFall[i] = !fields[4*i+3] && fields[4*i];
        end
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    sequence readOf(logic [7:0] a);
        regReq.rd && regReq.addr == a;
    endsequence
    for (genvar i = 0; i < 4; i++) begin : g_unit
        out_enable_a: assert property (pinDrive[i].enable_n == $past(offMode[i]))
            else $error("pin enable does not follow field");
        init_level_a: assert property (wrote[i] && !fields[4*i+3] |=> pinDrive[i].level == $past(initLvl[i]))
            else $error("initial level not loaded");
        no_rise_a: assert property ($rose(pinDrive[i].level) |-> $past(wrote[i]) || $past(canRise[i]))
            else $error("pin rose in a mode that cannot raise it");
        no_fall_a: assert property ($fell(pinDrive[i].level) |-> $past(wrote[i]) || $past(canFall[i]))
            else $error("pin fell in a mode that cannot lower it");
        off_hold_a: assert property ($changed(pinDrive[i].level) |-> $past(wrote[i]) || !$past(pinDrive[i].enable_n))
            else $error("disabled pin changed level");
    end
    ctrl1_read_a: assert property (readOf(`TIO_OFS_CHAN1_CTRL) |=> regRdData == {8'h00, $past(ctrl1)})
        else $error("chan1 control read wrong");
    ctrl2_read_a: assert property (readOf(`TIO_OFS_CHAN2_CTRL) |=> regRdData == {8'h00, $past(ctrl2)})
        else $error("chan2 control read wrong");
    idle_read_a: assert property (!$past(regReq.rd) |-> regRdData == 16'h0000)
        else $error("read data outside read cycle");
    unmapped_read_a: assert property (regReq.rd && !(regReq.addr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
        8'h14, 8'h18}) |=> regRdData == 16'h0000)
        else $error("unmapped read not zero");
endmodule : timer_io_control_ch1_ch2_props

// >>> timer_pin_partner.sv
// far side: external pin drivers and channel 0 event lines
`timescale 1ns/1ps
module timer_pin_partner
    import tio_pkg::*;
(
    input  wire pin_drive_s [3:0] pinDrive,    // block pin drive
    input  wire logic [3:0]       extLevel,    // level of the external driver
    input  wire logic             fireA,       // chan0 reg a event request
    input  wire logic             fireC,       // chan0 reg c event request
    output      logic [3:0]       pinIn,       // resolved pin levels
    output      logic             chan0EventA, // chan0 reg a event
    output      logic             chan0EventC  // chan0 reg c event
);
    // external driver only wins while the block has released the pin
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pinIn[i] = !pinDrive[i].enable_n ? pinDrive[i].level : extLevel[i];
        end
    end
    assign chan0EventA = fireA;
    assign chan0EventC = fireC;
endmodule : timer_pin_partner

// >>> timer_io_control_ch1_ch2_tb.sv
// self-checking bench for the timer i/o control block
`timescale 1ns/1ps
`include "tio_params.svh"
module timer_io_control_ch1_ch2_tb
    import tio_pkg::*;
();
    logic             clock;
    logic             reset_n;
    reg_req_s         regReq;
    logic [15:0]      regRdData;
    logic [15:0]      counterValue;
    logic             chan0EventA;
    logic             chan0EventC;
    logic [3:0]       pinIn;
    pin_drive_s [3:0] pinDrive;
    logic [3:0]       extLevel;
    logic             fireA;
    logic             fireC;
    int               numErrors;
    int               comparisons;

    timer_io_control_ch1_ch2 dut (.clock(clock), .reset_n(reset_n), .regReq(regReq), .regRdData(regRdData),
        .counterValue(counterValue), .chan0EventA(chan0EventA), .chan0EventC(chan0EventC), .pinIn(pinIn),
        .pinDrive(pinDrive));
    timer_pin_partner far (.pinDrive(pinDrive), .extLevel(extLevel), .fireA(fireA), .fireC(fireC),
        .pinIn(pinIn), .chan0EventA(chan0EventA), .chan0EventC(chan0EventC));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task cycles(input int n);
        repeat (n) @(posedge clock);
    endtask : cycles
    task check(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            numErrors++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask : check
    task writeReg(input logic [7:0] a, input logic [15:0] d);
        regReq <= '{a, d, 1'b1, 1'b0};
        @(posedge clock);
        regReq.wr <= 1'b0;
        @(posedge clock);
    endtask : writeReg
    task readCheck(input logic [7:0] a, input logic [15:0] e, input string n);
        logic [15:0] d;
        regReq <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge clock);
        regReq.rd <= 1'b0;
        #1 d = regRdData;
        @(posedge clock);
        check(n, e, d);
    endtask : readCheck
    task checkPins(input logic [3:0] lvl, input logic [3:0] en);
        // look mid-cycle so the pin drive is settled, then hand back on a rising edge
        @(negedge clock);
        for (int i = 0; i < 4; i++) begin
            check("pin level", 16'(lvl[i]), 16'(pinDrive[i].level));
            check("pin enable_n", 16'(en[i]), 16'(pinDrive[i].enable_n));
        end
        @(posedge clock);
    endtask : checkPins
    task ramp();
        for (int i = 0; i < 32; i++) begin
            counterValue <= 16'(i);
            @(posedge clock);
        end
        counterValue <= 16'h0000;
        cycles(3);
    endtask : ramp
    task stimulate(input int k, input int u, input logic [15:0] x);
        counterValue <= x;
        @(posedge clock);
        if (k < 2) extLevel[u] <= (k == 0);
        else if (k == 2) fireA <= 1'b1;
        else fireC <= 1'b1;
        @(posedge clock);
        fireA <= 1'b0;
        fireC <= 1'b0;
        cycles(8);
    endtask : stimulate
    task results();
        $display("errors %0d comparisons %0d", numErrors, comparisons);
        if (numErrors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results
    // ----------------------------------------
    // clock, watchdog and tests
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        numErrors++;
        results();
    end
    initial begin : main
        int u;
        int c;
        int k;
        logic viaCross;
        logic take;
        logic [15:0] x;
        logic [15:0] e;
        reset_n = 1'b0;
        regReq = '0;
        counterValue = 16'h0000;
        extLevel = 4'h0;
        fireA = 1'b0;
        fireC = 1'b0;
        numErrors = 0;
        comparisons = 0;
        cycles(20);
        reset_n <= 1'b1;
        @(posedge clock);
        readCheck(`TIO_OFS_CHAN1_CTRL, 16'h0000, "chan1 ctrl");
        readCheck(`TIO_OFS_CHAN2_CTRL, 16'h0000, "chan2 ctrl");
        checkPins(4'b0000, 4'b1111);
        writeReg(`TIO_OFS_CHAN1_CTRL, 16'hFF25);
        readCheck(`TIO_OFS_CHAN1_CTRL, 16'h0025, "chan1 ctrl");
        writeReg(8'h20, 16'h1234);
        readCheck(8'h20, 16'h0000, "unmapped");
        readCheck(`TIO_OFS_CHAN1_CTRL, 16'h0025, "chan1 ctrl");
        for (u = 0; u < 3; u++) writeReg(`TIO_OFS_CHAN1_GR_A + 8'(4 * u), 16'h0010);
        // chan2: reg a toggles from 0, reg b disabled with level 1
        writeReg(`TIO_OFS_CHAN2_CTRL, 16'h0043);
        cycles(2);
        checkPins(4'b1001, 4'b1000);
        ramp();
        checkPins(4'b1110, 4'b1000);
        ramp();
        checkPins(4'b1010, 4'b1000);
        // match flags of units 0..2 set by the ramps, pin levels 1010, no captures yet
        readCheck(`TIO_OFS_STATUS, 16'h0A70, "status");
        writeReg(`TIO_OFS_STATUS, 16'h00F0);
        readCheck(`TIO_OFS_STATUS, 16'h0A00, "status");
        for (u = 0; u < 4; u++) begin
            for (c = 8; c < 16; c++) begin
                viaCross = (u < 2) && c[2];
                writeReg(u < 2 ? `TIO_OFS_CHAN1_CTRL : `TIO_OFS_CHAN2_CTRL, 16'(c << (4 * (u % 2))));
                writeReg(`TIO_OFS_CHAN1_GR_A + 8'(4 * u), 16'h0000);
                e = 16'h0000;
                for (k = 0; k < 4; k++) begin
                    x = {u[3:0], c[3:0], k[3:0], 4'h1};
                    take = viaCross ? (k - 2 == u) : (k == 0 ? (c[1] || !c[0]) : k == 1 && (c[1] || c[0]));
                    stimulate(k, u, x);
                    e = take ? x : e;
                    readCheck(`TIO_OFS_CHAN1_GR_A + 8'(4 * u), e, "general reg");
                end
            end
        end
        reset_n <= 1'b0;
        cycles(3);
        reset_n <= 1'b1;
        @(posedge clock);
        readCheck(`TIO_OFS_CHAN2_CTRL, 16'h0000, "chan2 ctrl");
        checkPins(4'b0000, 4'b1111);
        results();
    end
endmodule : timer_io_control_ch1_ch2_tb

bind timer_io_control_ch1_ch2 timer_io_control_ch1_ch2_props props (.clock(clock), .reset_n(reset_n),
    .regReq(regReq), .regRdData(regRdData), .counterValue(counterValue), .chan0EventA(chan0EventA),
    .chan0EventC(chan0EventC), .pinIn(pinIn), .pinDrive(pinDrive));
